// ===== dct_pkg.sv
// Constants, register map and encodings of the debug data compare and trace unit.
// Assumes a single 10 MHz bus clock and a synchronous active-high reset.
package dct_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register indices; byte address is four times the index
	localparam logic [ADDR_W-1:0] IDX_CONTROL = 8'h20;
	localparam logic [ADDR_W-1:0] IDX_MASK = 8'h21;
	localparam logic [ADDR_W-1:0] IDX_STATUS = 8'h22;
	localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 8'h23;
	localparam logic [ADDR_W-1:0] IDX_TRACE_COUNT = 8'h24;
	localparam logic [ADDR_W-1:0] IDX_TRACE_SEL = 8'h25;
	localparam logic [ADDR_W-1:0] IDX_TRACE_WORD = 8'h26;
	localparam logic [ADDR_W-1:0] IDX_TRACE_INFO = 8'h27;
	localparam logic [ADDR_W-1:0] IDX_DATA_HIGH = 8'h2c;
	localparam logic [ADDR_W-1:0] IDX_DATA_LOW = 8'h2d;

	// Control register fields
	localparam int CTL_VIEW_LSB = 0;
	localparam int CTL_ARM = 2;
	localparam int CTL_TAG = 3;
	localparam int CTL_TRACE_EN = 4;
	localparam int CTL_MODE_LSB = 5;

	// Status and interrupt mask fields
	localparam int ST_MATCH = 0;
	localparam int ST_FULL = 1;
	localparam int ST_W = 2;

	// Reset values
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [15:0] MASK_RST = 16'h0000;
	localparam logic [7:0] DATA_HIGH_RST = 8'h00;
	localparam logic [7:0] DATA_LOW_RST = 8'h00;

	// View select value that exposes the data bytes
	localparam logic [1:0] VIEW_DATA = 2'b00;

	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		DCT_MODE_NORMAL = 2'b00,
		DCT_MODE_LOOP = 2'b01,
		DCT_MODE_DETAIL = 2'b10,
		DCT_MODE_RSVD = 2'b11
	} dct_mode_t;

	typedef enum logic [1:0] {
		DCT_KIND_SOURCE = 2'b00,
		DCT_KIND_DEST = 2'b01,
		DCT_KIND_VECTOR = 2'b10,
		DCT_KIND_ACCESS = 2'b11
	} dct_kind_t;

endpackage

// ===== dct_unit.sv
// Comparator A data match and trace buffer capture, with an AXI4-Lite register slave.
// Assumes CPU bus and flow signals come from logic on the same clock.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

module dct_unit #(
	parameter int DEPTH = 64
) (
	input wire logic clk, // Bus clock
	input wire logic rst, // Synchronous reset
	input wire logic [7:0] s_awaddr, // Write address
	input wire logic s_awvalid, // Write address valid
	output logic s_awready, // Write address ready
	input wire logic [31:0] s_wdata, // Write data
	input wire logic [3:0] s_wstrb, // Write strobes
	input wire logic s_wvalid, // Write data valid
	output logic s_wready, // Write data ready
	output logic [1:0] s_bresp, // Write response
	output logic s_bvalid, // Write response valid
	input wire logic s_bready, // Write response ready
	input wire logic [7:0] s_araddr, // Read address
	input wire logic s_arvalid, // Read address valid
	output logic s_arready, // Read address ready
	output logic [31:0] s_rdata, // Read data
	output logic [1:0] s_rresp, // Read response
	output logic s_rvalid, // Read data valid
	input wire logic s_rready, // Read data ready
	input wire logic bus_valid, // CPU access this cycle
	input wire logic [15:0] bus_addr, // CPU access address
	input wire logic [15:0] bus_data, // CPU data bus
	input wire logic [1:0] bus_byte_en, // Address bytes taking part
	input wire logic cof_valid, // Change-of-flow address offered
	input wire logic [1:0] cof_kind, // Source, destination or vector
	input wire logic [15:0] cof_addr, // Change-of-flow address
	output logic match_a, // Comparator A data match
	output logic irq // Interrupt level
);

	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam int ENT_W = 36;
	localparam logic [CNT_W-1:0] DEPTH_CNT = CNT_W'(DEPTH);
	localparam int ADDR_IDX_W = 6;

	// Register state
	logic [7:0] control;
	logic [15:0] data_mask;
	logic [7:0] cmp_high;
	logic [7:0] cmp_low;
	logic [dct_pkg::ST_W-1:0] status;
	logic [dct_pkg::ST_W-1:0] irq_mask;
	logic [PTR_W-1:0] trace_sel;

	// Bus slave state
	logic aw_have;
	logic w_have;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	// Trace state
	logic [ENT_W-1:0] trace_mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [CNT_W-1:0] trace_count;
	logic [15:0] last_addr;
	logic last_valid; // Cleared buffer has no entry to repeat

	// Decoded views
	logic [1:0] view;
	logic armed;
	logic tag_sel;
	logic trace_en;
	dct_pkg::dct_mode_t mode;
	logic [15:0] cmp_value;
	logic data_hit;
	logic wr_fire;
	logic wr_ok;
	logic trace_clear;
	logic [ADDR_IDX_W-1:0] wr_idx;
	logic [ADDR_IDX_W-1:0] rd_idx;
	logic data_view;
	logic data_wr_ok;
	logic store;
	logic [ENT_W-1:0] next_entry;
	logic trace_full;
	logic [dct_pkg::ST_W-1:0] events;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	assign view = control[dct_pkg::CTL_VIEW_LSB +: 2];
	assign armed = control[dct_pkg::CTL_ARM];
	assign tag_sel = control[dct_pkg::CTL_TAG];
	assign trace_en = control[dct_pkg::CTL_TRACE_EN];
	assign mode = dct_pkg::dct_mode_t'(control[dct_pkg::CTL_MODE_LSB +: 2]);
	assign data_view = (view == dct_pkg::VIEW_DATA);

	// Comparator A data compare
	assign cmp_value = {cmp_high, cmp_low};
	assign data_hit = bus_valid && !tag_sel
		&& ((bus_data ^ cmp_value) & data_mask) == 16'h0000;

	always_ff @(posedge clk) begin
		if (rst) begin
			match_a <= 1'b0;
		end else begin
			match_a <= data_hit;
		end
	end

	// Write channel handshake
	assign wr_fire = aw_have && w_have && !s_bvalid;
	assign wr_idx = aw_addr[7:2];
	assign rd_idx = s_araddr[7:2];
	assign data_wr_ok = data_view && !armed;
	assign wr_ok = wr_fire && (aw_addr[1:0] == 2'b00) && w_strb[0];
	assign trace_clear = wr_ok && (wr_idx == dct_pkg::IDX_TRACE_COUNT[5:0]);

	always_ff @(posedge clk) begin
		if (rst) begin
			aw_have <= 1'b0;
			s_awready <= 1'b1;
			aw_addr <= 8'h00;
		end else if (s_awvalid && s_awready) begin
			aw_have <= 1'b1;
			s_awready <= 1'b0;
			aw_addr <= s_awaddr;
		end else if (wr_fire) begin
			aw_have <= 1'b0;
			s_awready <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			w_have <= 1'b0;
			s_wready <= 1'b1;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else if (s_wvalid && s_wready) begin
			w_have <= 1'b1;
			s_wready <= 1'b0;
			w_data <= s_wdata;
			w_strb <= s_wstrb;
		end else if (wr_fire) begin
			w_have <= 1'b0;
			s_wready <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_bvalid <= 1'b0;
			s_bresp <= dct_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_bvalid <= 1'b1;
			unique case (wr_idx)
				dct_pkg::IDX_CONTROL[5:0], dct_pkg::IDX_MASK[5:0],
				dct_pkg::IDX_STATUS[5:0], dct_pkg::IDX_IRQ_MASK[5:0],
				dct_pkg::IDX_TRACE_COUNT[5:0], dct_pkg::IDX_TRACE_SEL[5:0],
				dct_pkg::IDX_TRACE_WORD[5:0], dct_pkg::IDX_TRACE_INFO[5:0],
				dct_pkg::IDX_DATA_HIGH[5:0], dct_pkg::IDX_DATA_LOW[5:0]: begin
					s_bresp <= (aw_addr[1:0] == 2'b00) ? dct_pkg::RESP_OKAY
						: dct_pkg::RESP_SLVERR;
				end
				default: begin
					s_bresp <= dct_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_bvalid && s_bready) begin
			s_bvalid <= 1'b0;
		end
	end

	// Configuration registers
	always_ff @(posedge clk) begin
		if (rst) begin
			control <= dct_pkg::CONTROL_RST;
		end else if (wr_ok && wr_idx == dct_pkg::IDX_CONTROL[5:0]) begin
			control <= w_data[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			data_mask <= dct_pkg::MASK_RST;
		end else if (wr_ok && wr_idx == dct_pkg::IDX_MASK[5:0]) begin
			data_mask[7:0] <= w_data[7:0];
			if (w_strb[1]) begin
				data_mask[15:8] <= w_data[15:8];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_mask <= '0;
		end else if (wr_ok && wr_idx == dct_pkg::IDX_IRQ_MASK[5:0]) begin
			irq_mask <= w_data[dct_pkg::ST_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			trace_sel <= '0;
		end else if (wr_ok && wr_idx == dct_pkg::IDX_TRACE_SEL[5:0]) begin
			trace_sel <= w_data[PTR_W-1:0];
		end
	end

	// Comparator A data bytes, write-protected by view and arming
	always_ff @(posedge clk) begin
		if (rst) begin
			cmp_high <= dct_pkg::DATA_HIGH_RST;
			cmp_low <= dct_pkg::DATA_LOW_RST;
		end else if (wr_ok && data_wr_ok) begin
			if (wr_idx == dct_pkg::IDX_DATA_HIGH[5:0]) begin
				cmp_high <= w_data[7:0];
			end
			if (wr_idx == dct_pkg::IDX_DATA_LOW[5:0]) begin
				cmp_low <= w_data[7:0];
			end
		end
	end

	// Trace capture
	assign trace_full = (trace_count == DEPTH_CNT);

	always_comb begin
		store = 1'b0;
		next_entry = '0;
		if (trace_en && !trace_full) begin
			unique case (mode)
				dct_pkg::DCT_MODE_NORMAL: begin
					store = cof_valid;
					next_entry = {2'b00, cof_kind, cof_addr, 16'h0000};
				end
				dct_pkg::DCT_MODE_LOOP: begin
					store = cof_valid && !(cof_kind == dct_pkg::DCT_KIND_SOURCE
						&& last_valid && cof_addr == last_addr);
					next_entry = {2'b00, cof_kind, cof_addr, 16'h0000};
				end
				dct_pkg::DCT_MODE_DETAIL: begin
					store = bus_valid;
					next_entry = {bus_byte_en, dct_pkg::DCT_KIND_ACCESS, bus_addr, bus_data};
				end
				dct_pkg::DCT_MODE_RSVD: begin
					store = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (store) begin
			trace_mem[wr_ptr] <= next_entry;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr <= '0;
			trace_count <= '0;
		end else if (trace_clear) begin
			wr_ptr <= '0;
			trace_count <= '0;
		end else if (store) begin
			wr_ptr <= wr_ptr + 1'b1;
			trace_count <= trace_count + 1'b1;
		end
	end

	// Loop filter copy of the last stored address
	always_ff @(posedge clk) begin
		if (rst) begin
			last_addr <= 16'h0000;
			last_valid <= 1'b0;
		end else if (trace_clear) begin
			last_valid <= 1'b0;
		end else if (store) begin
			last_addr <= next_entry[31:16];
			last_valid <= 1'b1;
		end
	end

	// Sticky status, set wins over write-one-to-clear
	assign events = {trace_en && trace_full, data_hit};

	always_ff @(posedge clk) begin
		if (rst) begin
			status <= '0;
		end else if (wr_ok && wr_idx == dct_pkg::IDX_STATUS[5:0]) begin
			status <= (status & ~w_data[dct_pkg::ST_W-1:0]) | events;
		end else begin
			status <= status | events;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & irq_mask);
		end
	end

	// Read decode
	always_comb begin
		next_rdata = 32'h00000000;
		next_rresp = dct_pkg::RESP_OKAY;
		if (s_araddr[1:0] != 2'b00) begin
			next_rresp = dct_pkg::RESP_SLVERR;
		end else begin
			unique case (rd_idx)
				dct_pkg::IDX_CONTROL[5:0]: next_rdata = {24'h000000, control};
				dct_pkg::IDX_MASK[5:0]: next_rdata = {16'h0000, data_mask};
				dct_pkg::IDX_STATUS[5:0]: next_rdata = {30'h00000000, status};
				dct_pkg::IDX_IRQ_MASK[5:0]: next_rdata = {30'h00000000, irq_mask};
				dct_pkg::IDX_TRACE_COUNT[5:0]: next_rdata = 32'(trace_count);
				dct_pkg::IDX_TRACE_SEL[5:0]: next_rdata = 32'(trace_sel);
				dct_pkg::IDX_TRACE_WORD[5:0]: next_rdata = trace_mem[trace_sel][31:0];
				dct_pkg::IDX_TRACE_INFO[5:0]: next_rdata = {28'h0000000, trace_mem[trace_sel][35:32]};
				dct_pkg::IDX_DATA_HIGH[5:0]: next_rdata = {24'h000000, data_view ? cmp_high : 8'h00};
				dct_pkg::IDX_DATA_LOW[5:0]: next_rdata = {24'h000000, data_view ? cmp_low : 8'h00};
				default: next_rresp = dct_pkg::RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_arready <= 1'b1;
			s_rvalid <= 1'b0;
			s_rdata <= 32'h00000000;
			s_rresp <= dct_pkg::RESP_OKAY;
		end else if (s_arvalid && s_arready) begin
			s_arready <= 1'b0;
			s_rvalid <= 1'b1;
			s_rdata <= next_rdata;
			s_rresp <= next_rresp;
		end else if (s_rvalid && s_rready) begin
			s_rvalid <= 1'b0;
			s_arready <= 1'b1;
		end
	end

endmodule // dct_unit

`default_nettype wire

// ===== dct_unit_props.sv
// Port checker for the data compare and trace unit.
// Bound into every dct_unit; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module dct_unit_props (
	input wire logic clk, // Clock
	input wire logic rst, // Reset
	input wire logic s_awvalid, // Aw valid
	input wire logic s_awready, // Aw ready
	input wire logic s_wvalid, // W valid
	input wire logic s_wready, // W ready
	input wire logic [1:0] s_bresp, // B resp
	input wire logic s_bvalid, // B valid
	input wire logic s_bready, // B ready
	input wire logic s_arvalid, // Ar valid
	input wire logic s_arready, // Ar ready
	input wire logic [31:0] s_rdata, // R data
	input wire logic [1:0] s_rresp, // R resp
	input wire logic s_rvalid, // R valid
	input wire logic s_rready, // R ready
	input wire logic bus_valid, // CPU access
	input wire logic match_a // Data match
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	a_match_needs_access: assert property (match_a |-> $past(bus_valid))
		else $error("match without access");
	a_write_answer: assert property (s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid)
		else $error("write response late");
	a_aw_held: assert property (s_awvalid && s_awready |=> !s_awready)
		else $error("write address taken twice");
	a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid && !s_arready)
		else $error("read answer late");
	a_b_stands: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
		else $error("write response dropped");
	a_r_stands: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
		else $error("read data dropped");
	a_err_reads_zero: assert property (s_rvalid && s_rresp == dct_pkg::RESP_SLVERR |-> s_rdata == 0)
		else $error("refused read not zero");
	a_b_legal: assert property (s_bvalid |-> s_bresp == 2'h0 || s_bresp == 2'h2)
		else $error("illegal write response");
endmodule // dct_unit_props

bind dct_unit dct_unit_props u_props (.clk(clk), .rst(rst), .s_awvalid(s_awvalid),
	.s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
	.s_bvalid(s_bvalid), .s_bready(s_bready), .s_arvalid(s_arvalid), .s_arready(s_arready),
	.s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
	.bus_valid(bus_valid), .match_a(match_a));
`default_nettype wire

// ===== dct_cpu_model.sv
// CPU side stand-in: bus accesses and change-of-flow entries.
// Tasks are called by the bench; released lines show inverted data.
`timescale 1ns/100ps
`default_nettype none
module dct_cpu_model (
	input wire logic clk, // Clock
	output logic bus_valid, // Access
	output logic [15:0] bus_addr, // Address
	output logic [15:0] bus_data, // Data
	output logic [1:0] bus_byte_en, // Info bits
	output logic cof_valid, // Flow entry
	output logic [1:0] cof_kind, // Entry kind
	output logic [15:0] cof_addr // Flow address
);
	initial begin
		{bus_valid, bus_addr, bus_data, bus_byte_en, cof_valid, cof_kind, cof_addr} = '0;
	end
	task access(input logic [15:0] a, d, input logic [1:0] be);
		@(posedge clk);
		bus_valid <= 1'b1;
		bus_addr <= a;
		bus_data <= d;
		bus_byte_en <= be;
		@(posedge clk);
		bus_valid <= 1'b0;
		bus_data <= ~d;
	endtask
	task flow(input logic [1:0] k, input logic [15:0] a);
		@(posedge clk);
		cof_valid <= 1'b1;
		cof_kind <= k;
		cof_addr <= a;
		@(posedge clk);
		cof_valid <= 1'b0;
		cof_addr <= ~a;
	endtask
endmodule // dct_cpu_model
`default_nettype wire

// ===== test_dct_unit.sv
// Self-checking bench for the data compare and trace unit.
// Drives the register bus itself and the CPU side through dct_cpu_model.
`timescale 1ns/100ps
`default_nettype none
module test_dct_unit;
	logic clk = 0;
	logic rst = 1;
	logic [7:0] s_awaddr, s_araddr, h, l;
	logic [31:0] s_wdata, s_rdata;
	logic [3:0] s_wstrb = 4'hf;
	logic [1:0] s_bresp, s_rresp, bus_byte_en, cof_kind;
	logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready, s_arvalid, s_arready;
	logic s_rvalid, s_rready, bus_valid, cof_valid, match_a, irq, tag, pv = 0;
	logic [15:0] bus_addr, bus_data, cof_addr, m;
	logic [63:0] q;
	logic [63:0] rq[$];
	logic [1:0] bq[$], pq[$];
	logic mq[$];
	int n_errors = 0;
	int checks = 0;
	logic [17:0] fl[9] = '{18'h01000, 18'h12000, 18'h2fff2, 18'h12004, 18'h02004, 18'h02004,
		18'h2fff2, 18'h2fff2, 18'h13010};
	logic [17:0] ex[8] = '{18'h01000, 18'h12000, 18'h2fff2, 18'h12004, 18'h02004, 18'h2fff2,
		18'h2fff2, 18'h13010};
	always #50 clk = ~clk;
	dct_unit #(.DEPTH(4)) u_dct_unit (.clk(clk), .rst(rst), .s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
		.s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
		.s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
		.bus_valid(bus_valid), .bus_addr(bus_addr), .bus_data(bus_data),
		.bus_byte_en(bus_byte_en), .cof_valid(cof_valid), .cof_kind(cof_kind),
		.cof_addr(cof_addr), .match_a(match_a), .irq(irq));
	dct_cpu_model u_dct_cpu_model (.clk(clk), .bus_valid(bus_valid), .bus_addr(bus_addr),
		.bus_data(bus_data), .bus_byte_en(bus_byte_en), .cof_valid(cof_valid),
		.cof_kind(cof_kind), .cof_addr(cof_addr));
	task cmp(input string n, input logic [31:0] e, s);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task close_out;
		if (n_errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task wr(input logic [7:0] i, input logic [31:0] d, input logic [1:0] r = 2'h0);
		logic a, w;
		a = 1;
		w = 1;
		bq.push_back(r);
		s_awaddr <= {i[5:0], 2'b00};
		s_wdata <= d;
		s_awvalid <= 1;
		s_wvalid <= 1;
		s_bready <= 1;
		while (a || w) begin
			@(posedge clk);
			a = a && !s_awready;
			w = w && !s_wready;
			s_awvalid <= a;
			s_wvalid <= w;
		end
		do @(posedge clk); while (!s_bvalid);
		s_bready <= 0;
	endtask
	task rd(input logic [7:0] i, input logic [31:0] e, input logic [31:0] k = '1,
		input logic [1:0] r = 2'h0);
		rq.push_back({k, e & k});
		pq.push_back(r);
		s_araddr <= {i[5:0], 2'b00};
		s_arvalid <= 1;
		s_rready <= 1;
		do @(posedge clk); while (!s_arready);
		s_arvalid <= 0;
		do @(posedge clk); while (!s_rvalid);
		s_rready <= 0;
	endtask
	task acc(input logic [15:0] a, d, input logic [1:0] be = 2'b11);
		mq.push_back(!tag && ((d ^ {h, l}) & m) == 16'h0);
		u_dct_cpu_model.access(a, d, be);
	endtask
	task irq_is(input logic e);
		repeat (2) @(posedge clk);
		cmp("irq", {31'h0, e}, {31'h0, irq});
	endtask
	always @(posedge clk) begin
		if (s_bvalid && s_bready)
			cmp("bresp", {30'h0, bq.pop_front()}, {30'h0, s_bresp});
		if (s_rvalid && s_rready) begin
			q = rq.pop_front();
			cmp("rdata", q[31:0], s_rdata & q[63:32]);
			cmp("rresp", {30'h0, pq.pop_front()}, {30'h0, s_rresp});
		end
	end
	// Match result lands one cycle after the access
	always @(posedge clk) begin
		#1;
		if (pv)
			cmp("match_a", {31'h0, mq.pop_front()}, {31'h0, match_a});
		pv = bus_valid;
	end
	initial begin
		repeat (4000) @(posedge clk);
		n_errors++;
		close_out();
	end
	initial begin
		{s_awaddr, s_awvalid, s_wdata, s_wvalid, s_bready, s_araddr, s_arvalid, s_rready} = '0;
		{h, l, m, tag} = '0;
		void'($urandom(32'h4d66));
		repeat (3) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		rd(dct_pkg::IDX_DATA_HIGH, 32'h0);
		wr(8'h30, 32'h1, dct_pkg::RESP_SLVERR);
		rd(8'h30, 32'h0, '1, dct_pkg::RESP_SLVERR);
		for (int i = 0; i < 16; i++) begin
			h = 8'($urandom);
			l = 8'($urandom);
			m = i == 0 ? 16'h0 : i == 1 ? 16'hffff : 16'($urandom);
			wr(dct_pkg::IDX_DATA_HIGH, {24'h0, h});
			wr(dct_pkg::IDX_DATA_LOW, {24'h0, l});
			wr(dct_pkg::IDX_MASK, {16'h0, m});
			rd(dct_pkg::IDX_DATA_HIGH, {24'h0, h});
			acc(16'h0100, {h, l});
			acc(16'h0102, {h, l} ^ (16'h1 << i));
			acc(16'h0104, 16'($urandom));
		end
		wr(dct_pkg::IDX_CONTROL, 32'h1);
		rd(dct_pkg::IDX_DATA_HIGH, 32'h0);
		wr(dct_pkg::IDX_DATA_LOW, {24'h0, ~l});
		wr(dct_pkg::IDX_CONTROL, 32'h4);
		wr(dct_pkg::IDX_DATA_LOW, {24'h0, ~l});
		rd(dct_pkg::IDX_DATA_LOW, {24'h0, l});
		wr(dct_pkg::IDX_CONTROL, 32'h8);
		tag = 1;
		acc(16'h0100, {h, l});
		tag = 0;
		rd(dct_pkg::IDX_STATUS, 32'h1, 32'h1);
		irq_is(0);
		wr(dct_pkg::IDX_IRQ_MASK, 32'h1);
		irq_is(1);
		wr(dct_pkg::IDX_STATUS, 32'h1);
		irq_is(0);
		for (int j = 0; j < 2; j++) begin
			wr(dct_pkg::IDX_CONTROL, j ? 32'h30 : 32'h10);
			wr(dct_pkg::IDX_TRACE_COUNT, 32'h0);
			wr(dct_pkg::IDX_STATUS, 32'h2);
			for (int k = j * 4; k < j * 5 + 4; k++)
				u_dct_cpu_model.flow(fl[k][17:16], fl[k][15:0]);
			rd(dct_pkg::IDX_TRACE_COUNT, 32'h4);
			rd(dct_pkg::IDX_STATUS, 32'h2, 32'h2);
			for (int k = 0; k < 4; k++) begin
				wr(dct_pkg::IDX_TRACE_SEL, 32'(k));
				rd(dct_pkg::IDX_TRACE_WORD, {ex[j * 4 + k][15:0], 16'h0}, 32'hffff0000);
				rd(dct_pkg::IDX_TRACE_INFO, {30'h0, ex[j * 4 + k][17:16]}, 32'h3);
			end
		end
		wr(dct_pkg::IDX_CONTROL, 32'h50);
		wr(dct_pkg::IDX_TRACE_COUNT, 32'h0);
		acc(16'h3456, 16'h789a, 2'b10);
		wr(dct_pkg::IDX_TRACE_SEL, 32'h0);
		rd(dct_pkg::IDX_TRACE_WORD, 32'h3456789a);
		rd(dct_pkg::IDX_TRACE_INFO, 32'hb, 32'hf);
		rd(dct_pkg::IDX_TRACE_COUNT, 32'h1);
		wr(dct_pkg::IDX_CONTROL, 32'h70);
		wr(dct_pkg::IDX_TRACE_COUNT, 32'h0);
		u_dct_cpu_model.flow(2'b01, 16'h4000);
		acc(16'h4002, 16'h0002);
		rd(dct_pkg::IDX_TRACE_COUNT, 32'h0);
		close_out();
	end
endmodule // test_dct_unit
`default_nettype wire
